/* File: rtl/system_memory_bus.sv */
// Operation
// RULE1: one bus cycle equals one system clock
// RULE2: split access into cycles by device width
// RULE3: peripheral area takes 8, 16, 32-bit
// RULE4: 16-bit access to registers takes one cycle
// RULE5: decode 16 MB space for fetch and data
// RULE6: 32-bit write stores zero upper byte
// RULE7: 32-bit read drops upper byte
// RULE8: stacking keeps status byte above return address
// RULE9: independent memories serve fetch and data together
// RULE10: same-memory conflicts stretch fetch by data cycles
// RULE11: vector table base is 0x8000 after reset
// RULE12: flash read cycles from two-bit wait field
// RULE13: software picks wait rated above clock
// RULE14: last 64 RAM bytes reserved for debug
// RULE15: three-bit field limits usable RAM size
// RULE16: RAM beyond limit reads as reserved
// RULE17: read-only register shows debug area start
// RULE18: protection blocks system control register writes
// RULE19: display RAM usable as general RAM
// RULE20: control registers at 0x4000, 8 KB window
// RULE21: conflicting data access completes before fetch
`timescale 1ns/1ps
`default_nettype none
module system_memory_bus #(
  parameter int IRAM_BYTES  = 2048,
  parameter int DRAM_BYTES  = 256,
  parameter int FLASH_BYTES = 4096
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output var  logic        awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output var  logic        wready,
  output var  logic [1:0]  bresp,
  output var  logic        bvalid,
  input  wire logic        bready,
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output var  logic        arready,
  output var  logic [31:0] rdata,
  output var  logic [1:0]  rresp,
  output var  logic        rvalid,
  input  wire logic        rready,
  input  wire logic        f_req,
  input  wire logic [23:0] f_addr,
  output var  logic [15:0] f_rdata,
  output var  logic        f_done,
  input  wire logic        d_req,
  input  wire logic [23:0] d_addr,
  input  wire logic [1:0]  d_size,
  input  wire logic        d_we,
  input  wire logic        d_stack,
  input  wire logic [31:0] d_wdata,
  output var  logic [31:0] d_rdata,
  output var  logic        d_done,
  output var  logic [23:0] vector_base
);
  localparam int IW = $clog2(IRAM_BYTES);
  localparam int DW = $clog2(DRAM_BYTES);
  localparam int FW = $clog2(FLASH_BYTES);

  ////////////////////////////////////////////////////////////////////////////
  // storage and state
  logic [7:0] iram_mem  [IRAM_BYTES];   // internal ram, 32-bit device
  logic [7:0] dram_mem  [DRAM_BYTES];   // display ram, free bytes are plain ram
  logic [7:0] flash_mem [FLASH_BYTES];  // data-port writes stand in for programming
  smb_pkg::state_type st_q;             // all control state
  smb_pkg::state_type st_d;             // its next value
  logic [23:0] ram_lim;                 // bytes of ram visible
  logic        d_start;                 // data access taken
  logic        f_start;                 // fetch taken
  logic        d_fin;                   // last data cycle
  logic [31:0] d_raw;                   // assembled data bytes
  logic [31:0] d_rd;                    // read word after width rules
  logic [15:0] f_raw;                   // assembled fetch bytes
  logic [31:0] weff;                    // write word after width rules
  logic [3:0]  wen_i;                   // per-lane ram write
  logic [3:0]  wen_d;                   // per-lane display ram write
  logic [3:0]  wen_f;                   // per-lane flash write
  logic [23:0] wa [4];                  // per-lane byte address

  localparam smb_pkg::state_type RST = '{
    fs: smb_pkg::P_IDLE, ds: smb_pkg::P_IDLE, fc: 4'h0, dc: 4'h0, fa: 24'h00_0000,
    da: 24'h00_0000, dsz: 2'h0, dwe: 1'b0, dstk: 1'b0, dwd: 32'h0000_0000,
    fdone: 1'b0, ddone: 1'b0, frd: 16'h0000, drd: 32'h0000_0000, unlocked: 1'b0,
    fwait: smb_pkg::FWAIT_RST, ramsel: smb_pkg::RAMSEL_RST, awrdy: 1'b1, wrdy: 1'b1,
    arrdy: 1'b1, bvalid: 1'b0, rvalid: 1'b0, bresp: 2'h0, rresp: 2'h0,
    awa: 12'h000, ara: 12'h000, wd: 32'h0000_0000, ws: 4'h0, rd: 32'h0000_0000,
    vbase: smb_pkg::VECTOR_BASE_RST};

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  // map a 24-bit address onto a device
  function automatic smb_pkg::region_type region(input logic [23:0] a);
    if (a < smb_pkg::IRAM_BASE + 24'(IRAM_BYTES)) return smb_pkg::RG_IRAM; // RULE5
    if (a >= smb_pkg::PERIPH_BASE && a < smb_pkg::PERIPH_BASE + smb_pkg::PERIPH_BYTES)
      return smb_pkg::RG_PERIPH; // RULE20
    if (a >= smb_pkg::DRAM_BASE && a < smb_pkg::DRAM_BASE + 24'(DRAM_BYTES))
      return smb_pkg::RG_DRAM; // RULE19
    if (a >= smb_pkg::FLASH_BASE && a < smb_pkg::FLASH_BASE + 24'(FLASH_BYTES))
      return smb_pkg::RG_FLASH;
    return smb_pkg::RG_NONE;
  endfunction

  // fetch and data on the same memory must take turns
  function automatic logic conflict(input smb_pkg::region_type fr, input smb_pkg::region_type dr);
    logic fl;
    logic rm;
    fl = (fr == smb_pkg::RG_FLASH) && (dr == smb_pkg::RG_FLASH || dr == smb_pkg::RG_DRAM);
    rm = (fr == smb_pkg::RG_IRAM || fr == smb_pkg::RG_DRAM)
      && (dr == smb_pkg::RG_IRAM || dr == smb_pkg::RG_DRAM);
    return fl || rm; // RULE10
  endfunction

  // bus cycles for one access: beats, times flash wait plus one on flash reads
  function automatic logic [3:0] cycles(input logic [1:0] sz, input smb_pkg::region_type rg,
                                        input logic we, input logic [1:0] w);
    logic [2:0] acc;
    logic [2:0] dev;
    logic [2:0] b;
    acc = 3'(1 << sz);
    dev = (rg == smb_pkg::RG_IRAM) ? smb_pkg::DEV_IRAM : smb_pkg::DEV_OTHER;
    b   = (acc > dev) ? 3'(acc / dev) : 3'h1; // RULE2
    if (rg == smb_pkg::RG_FLASH && !we) return 4'(b * ({1'b0, w} + 3'h1)); // RULE12
    return {1'b0, b};
  endfunction

  // register read, hit flag in bit 32
  function automatic logic [32:0] reg_rd(input smb_pkg::state_type s, input logic [11:0] o);
    logic [23:0] lim;
    lim = 24'(IRAM_BYTES) >> s.ramsel;
    case (o)
      smb_pkg::OFS_PROTECT: return {1'b1, 31'h0000_0000, s.unlocked};
      smb_pkg::OFS_RAMSZ:   return {1'b1, 29'h0000_0000, s.ramsel};
      smb_pkg::OFS_FLASH:   return {1'b1, 30'h0000_0000, s.fwait};
      smb_pkg::OFS_DBG:     return {1'b1, 8'h00, smb_pkg::IRAM_BASE + lim - smb_pkg::DBG_AREA_BYTES}; // RULE14 RULE17
      smb_pkg::OFS_STATUS:  return {1'b1, 30'h0000_0000, s.ds == smb_pkg::P_BUSY, s.fs == smb_pkg::P_BUSY};
      default:              return {1'b0, 32'h0000_0000};
    endcase
  endfunction

  // register write under byte mask; read-only registers ignore it
  function automatic smb_pkg::state_type reg_wr(input smb_pkg::state_type s, input logic [11:0] o,
                                                 input logic [31:0] v, input logic [31:0] m);
    smb_pkg::state_type r;
    r = s;
    case (o)
      smb_pkg::OFS_PROTECT: if (m[15:0] == 16'hffff) r.unlocked = (v[15:0] == smb_pkg::PROT_KEY);
      smb_pkg::OFS_FLASH:   if (s.unlocked) r.fwait = (s.fwait & ~m[1:0]) | (v[1:0] & m[1:0]); // RULE18
      smb_pkg::OFS_RAMSZ:   if (s.unlocked) r.ramsel = (s.ramsel & ~m[2:0]) | (v[2:0] & m[2:0]); // RULE15 RULE18
      default: ;
    endcase
    return r;
  endfunction

  // one byte from whichever device holds it
  function automatic logic [7:0] mbyte(input smb_pkg::state_type s, input logic [23:0] a);
    logic [32:0] pw;
    pw = reg_rd(s, {a[11:2], 2'b00});
    case (region(a))
      smb_pkg::RG_IRAM:   return (a >= ram_lim) ? 8'h00 : iram_mem[a[IW-1:0]]; // RULE16
      smb_pkg::RG_DRAM:   return dram_mem[a[DW-1:0]];
      smb_pkg::RG_FLASH:  return flash_mem[a[FW-1:0]];
      smb_pkg::RG_PERIPH: return a[12] ? 8'h00 : 8'(pw[31:0] >> {a[1:0], 3'b000}); // RULE3
      default:            return 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // arbitration between fetch and data
  assign ram_lim = 24'(IRAM_BYTES) >> st_q.ramsel; // RULE15
  // data goes unless a conflicting fetch is already on the memory
  assign d_start = st_q.ds == smb_pkg::P_IDLE && !st_q.ddone && d_req
                && !(st_q.fs == smb_pkg::P_BUSY && conflict(region(st_q.fa), region(d_addr)));
  // fetch waits for running or pending conflicting data; else runs alongside
  // it may join the last data cycle, so the stretch is exactly the data cycles
  assign f_start = st_q.fs == smb_pkg::P_IDLE && !st_q.fdone && f_req
                && !(st_q.ds == smb_pkg::P_BUSY && !d_fin && conflict(region(f_addr), region(st_q.da))) // RULE21
                && !(st_q.ds == smb_pkg::P_IDLE && d_req && !st_q.ddone
                     && conflict(region(f_addr), region(d_addr))); // RULE9 RULE10
  assign d_fin = st_q.ds == smb_pkg::P_BUSY && st_q.dc == 4'h0;

  ////////////////////////////////////////////////////////////////////////////
  // read assembly and width rules
  always_comb begin
    d_raw = 32'h0000_0000;
    f_raw = 16'h0000;
    for (int i = 0; i < 4; i++) d_raw[8*i +: 8] = mbyte(st_q, st_q.da + 24'(i));
    for (int i = 0; i < 2; i++) f_raw[8*i +: 8] = mbyte(st_q, st_q.fa + 24'(i));
    case (st_q.dsz)
      2'h0:    d_rd = {24'h00_0000, d_raw[7:0]};
      2'h1:    d_rd = {16'h0000, d_raw[15:0]};
      default: d_rd = st_q.dstk ? d_raw : {8'h00, d_raw[23:0]}; // RULE7 RULE8
    endcase
    // a plain 32-bit store carries only a 24-bit register
    weff = (st_q.dsz == 2'h2 && !st_q.dstk) ? {8'h00, st_q.dwd[23:0]} : st_q.dwd; // RULE6 RULE8
  end

  // per-lane write enables for the memories
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wa[i]    = st_q.da + 24'(i);
      wen_i[i] = d_fin && st_q.dwe && (i < (1 << st_q.dsz)) && region(wa[i]) == smb_pkg::RG_IRAM
              && wa[i] < ram_lim; // RULE16
      wen_d[i] = d_fin && st_q.dwe && (i < (1 << st_q.dsz)) && region(wa[i]) == smb_pkg::RG_DRAM; // RULE19
      wen_f[i] = d_fin && st_q.dwe && (i < (1 << st_q.dsz)) && region(wa[i]) == smb_pkg::RG_FLASH;
    end
  end

  // memory arrays hold no reset; contents are software's business
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 4; i++) begin
      if (wen_i[i]) iram_mem[wa[i][IW-1:0]] <= weff[8*i +: 8];
      if (wen_d[i]) dram_mem[wa[i][DW-1:0]] <= weff[8*i +: 8];
      if (wen_f[i]) flash_mem[wa[i][FW-1:0]] <= weff[8*i +: 8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state: ports, peripheral window, register bus
  always_comb begin
    logic [32:0] rr;
    logic [31:0] am;
    logic [31:0] pm;
    rr = 33'h0_0000_0000;
    am = 32'h0000_0000;
    pm = 32'h0000_0000;
    st_d = st_q;
    st_d.ddone = 1'b0;
    st_d.fdone = 1'b0;
    // data port
    case (st_q.ds)
      smb_pkg::P_IDLE: if (d_start) begin
        st_d.ds   = smb_pkg::P_BUSY;
        st_d.da   = d_addr;
        st_d.dsz  = d_stack ? 2'h2 : d_size; // RULE8
        st_d.dwe  = d_we;
        st_d.dstk = d_stack;
        st_d.dwd  = d_wdata;
        st_d.dc   = 4'(int'(cycles(d_stack ? 2'h2 : d_size, region(d_addr), d_we, st_q.fwait))
                    * smb_pkg::BUS_CYCLE_CLKS - 1); // RULE1 RULE2
      end
      smb_pkg::P_BUSY: if (st_q.dc == 4'h0) begin
        st_d.ds    = smb_pkg::P_IDLE;
        st_d.ddone = 1'b1;
        st_d.drd   = st_q.dwe ? 32'h0000_0000 : d_rd;
      end else begin
        st_d.dc = st_q.dc - 4'h1; // RULE1
      end
      default: st_d.ds = smb_pkg::P_IDLE;
    endcase
    // fetch port, always 16-bit
    case (st_q.fs)
      smb_pkg::P_IDLE: if (f_start) begin
        st_d.fs = smb_pkg::P_BUSY;
        st_d.fa = f_addr;
        st_d.fc = 4'(int'(cycles(2'h1, region(f_addr), 1'b0, st_q.fwait)) * smb_pkg::BUS_CYCLE_CLKS - 1);
      end
      smb_pkg::P_BUSY: if (st_q.fc == 4'h0) begin
        st_d.fs    = smb_pkg::P_IDLE;
        st_d.fdone = 1'b1;
        st_d.frd   = f_raw;
      end else begin
        st_d.fc = st_q.fc - 4'h1;
      end
      default: st_d.fs = smb_pkg::P_IDLE;
    endcase
    // bus write channels taken independently
    if (awvalid && st_q.awrdy) begin
      st_d.awrdy = 1'b0;
      st_d.awa   = awaddr;
    end
    if (wvalid && st_q.wrdy) begin
      st_d.wrdy = 1'b0;
      st_d.wd   = wdata;
      st_d.ws   = wstrb;
    end
    // both halves held: write, then answer
    if (!st_q.awrdy && !st_q.wrdy && !st_q.bvalid) begin
      for (int i = 0; i < 4; i++) am[8*i +: 8] = {8{st_q.ws[i]}};
      rr          = reg_rd(st_q, {st_q.awa[11:2], 2'b00});
      st_d.bvalid = 1'b1;
      st_d.bresp  = rr[32] ? smb_pkg::RESP_OKAY : smb_pkg::RESP_SLVERR;
      st_d        = reg_wr(st_d, {st_q.awa[11:2], 2'b00}, st_q.wd, am);
    end
    if (st_q.bvalid && bready) begin
      st_d.bvalid = 1'b0;
      st_d.awrdy  = 1'b1;
      st_d.wrdy   = 1'b1;
    end
    // bus read answers the cycle after the address
    if (arvalid && st_q.arrdy) begin
      rr          = reg_rd(st_q, {araddr[11:2], 2'b00});
      st_d.arrdy  = 1'b0;
      st_d.rvalid = 1'b1;
      st_d.ara    = araddr;
      st_d.rd     = rr[31:0];
      st_d.rresp  = rr[32] ? smb_pkg::RESP_OKAY : smb_pkg::RESP_SLVERR;
    end
    if (st_q.rvalid && rready) begin
      st_d.rvalid = 1'b0;
      st_d.arrdy  = 1'b1;
    end
    // core write into the register window lands after any bus write
    if (d_fin && st_q.dwe && region(st_q.da) == smb_pkg::RG_PERIPH && !st_q.da[12]) begin
      pm   = (st_q.dsz == 2'h0) ? 32'h0000_00ff : (st_q.dsz == 2'h1) ? 32'h0000_ffff : 32'hffff_ffff;
      st_d = reg_wr(st_d, {st_q.da[11:2], 2'b00}, weff << {st_q.da[1:0], 3'b000},
                    pm << {st_q.da[1:0], 3'b000}); // RULE3 RULE4
    end
  end

  // single state register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= RST; // RULE11
    end else begin
      st_q <= st_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from state
  assign awready     = st_q.awrdy;
  assign wready      = st_q.wrdy;
  assign bvalid      = st_q.bvalid;
  assign bresp       = st_q.bresp;
  assign arready     = st_q.arrdy;
  assign rvalid      = st_q.rvalid;
  assign rdata       = st_q.rd;
  assign rresp       = st_q.rresp;
  assign f_rdata     = st_q.frd;
  assign f_done      = st_q.fdone;
  assign d_rdata     = st_q.drd;
  assign d_done      = st_q.ddone;
  assign vector_base = st_q.vbase;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_cycle_count;
    st_q.ds == smb_pkg::P_BUSY && st_q.dc != 4'h0 |=> st_q.ds == smb_pkg::P_BUSY && st_q.dc == $past(st_q.dc) - 4'h1;
  endproperty
  a_cycle_count: assert property (p_cycle_count) else $error("data cycle count skipped"); // RULE1

  property p_dram_word;
    d_start && !d_stack && d_size == 2'h2 && region(d_addr) == smb_pkg::RG_DRAM
      |=> !st_q.ddone ##1 !st_q.ddone ##1 st_q.ddone;
  endproperty
  a_dram_word: assert property (p_dram_word) else $error("32-bit on 16-bit device not two cycles"); // RULE2

  property p_reg_one_cycle;
    d_start && !d_stack && d_size == 2'h1 && region(d_addr) == smb_pkg::RG_PERIPH |=> !st_q.ddone ##1 st_q.ddone;
  endproperty
  a_reg_one_cycle: assert property (p_reg_one_cycle) else $error("16-bit register access slow"); // RULE4

  property p_store_zero;
    d_fin && st_q.dwe && st_q.dsz == 2'h2 && !st_q.dstk |-> weff[31:24] == 8'h00;
  endproperty
  a_store_zero: assert property (p_store_zero) else $error("upper byte stored nonzero"); // RULE6

  property p_load_drop;
    d_fin && !st_q.dwe && st_q.dsz == 2'h2 && !st_q.dstk |=> st_q.ddone && st_q.drd[31:24] == 8'h00;
  endproperty
  a_load_drop: assert property (p_load_drop) else $error("upper byte not dropped"); // RULE7

  property p_stack_keep;
    d_fin && st_q.dwe && st_q.dstk |-> weff == st_q.dwd;
  endproperty
  a_stack_keep: assert property (p_stack_keep) else $error("status byte lost on stacking"); // RULE8

  property p_parallel;
    f_start && d_start |-> !conflict(region(f_addr), region(d_addr));
  endproperty
  a_parallel: assert property (p_parallel) else $error("conflicting ports ran together"); // RULE9

  property p_serial;
    st_q.ds == smb_pkg::P_BUSY && st_q.fs == smb_pkg::P_BUSY |-> !conflict(region(st_q.fa), region(st_q.da));
  endproperty
  a_serial: assert property (p_serial) else $error("same memory shared in one cycle"); // RULE10 RULE21

  property p_vector;
    vector_base == smb_pkg::VECTOR_BASE_RST;
  endproperty
  a_vector: assert property (p_vector) else $error("vector base moved"); // RULE11

  property p_flash_wait;
    d_start && !d_we && !d_stack && d_size == 2'h1 && region(d_addr) == smb_pkg::RG_FLASH
      |=> st_q.dc == 4'($past(st_q.fwait));
  endproperty
  a_flash_wait: assert property (p_flash_wait) else $error("flash wait not applied"); // RULE12

  property p_oor_read;
    d_fin && !st_q.dwe && region(st_q.da) == smb_pkg::RG_IRAM && st_q.da >= ram_lim
      |=> st_q.drd == 32'h0000_0000;
  endproperty
  a_oor_read: assert property (p_oor_read) else $error("ram beyond limit not reserved"); // RULE16

  property p_dbg_reg;
    arvalid && arready && {araddr[11:2], 2'b00} == smb_pkg::OFS_DBG
      |=> rvalid && rdata[31:24] == 8'h00 && rdata[23:0] == smb_pkg::IRAM_BASE + ram_lim - smb_pkg::DBG_AREA_BYTES;
  endproperty
  a_dbg_reg: assert property (p_dbg_reg) else $error("debug base wrong"); // RULE17

  property p_protect;
    !st_q.unlocked && !(d_fin && st_q.dwe) |=> st_q.fwait == $past(st_q.fwait) && st_q.ramsel == $past(st_q.ramsel);
  endproperty
  a_protect: assert property (p_protect) else $error("locked register changed"); // RULE18

  c_parallel: cover property (f_start && d_start);
  c_stall: cover property (f_req && !f_start && st_q.ds == smb_pkg::P_BUSY ##[1:20] f_start);
  c_flash_slow: cover property (d_start && region(d_addr) == smb_pkg::RG_FLASH && st_q.fwait == 2'h3);
  c_bus_write: cover property (bvalid && bready && bresp == smb_pkg::RESP_OKAY);
endmodule // system_memory_bus
`default_nettype wire

/* File: rtl/smb_pkg.sv */
package smb_pkg;
  // bus timing: one access cycle is one system clock period
  localparam int SYS_CLK_PERIOD_NS = 50;
  localparam int BUS_CYCLE_NS      = 50;
  localparam int BUS_CYCLE_CLKS    = (BUS_CYCLE_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  // address map
  localparam logic [23:0] IRAM_BASE       = 24'h00_0000;
  localparam logic [23:0] PERIPH_BASE     = 24'h00_4000;
  localparam logic [23:0] PERIPH_BYTES    = 24'h00_2000;
  localparam logic [23:0] DRAM_BASE       = 24'h00_6000;
  localparam logic [23:0] FLASH_BASE      = 24'h00_8000;
  localparam logic [23:0] VECTOR_BASE_RST = 24'h00_8000;
  localparam logic [23:0] DBG_AREA_BYTES  = 24'h00_0040;
  // register offsets, on the bus and inside the peripheral window
  localparam logic [11:0] OFS_PROTECT = 12'h000;
  localparam logic [11:0] OFS_RAMSZ   = 12'h004;
  localparam logic [11:0] OFS_FLASH   = 12'h008;
  localparam logic [11:0] OFS_DBG     = 12'h00c;
  localparam logic [11:0] OFS_STATUS  = 12'h010;
  // field values and reset values
  localparam logic [15:0] PROT_KEY   = 16'h0096;
  localparam logic [1:0]  FWAIT_RST  = 2'h3;
  localparam logic [2:0]  RAMSEL_RST = 3'h0;
  // device widths in bytes
  localparam logic [2:0] DEV_IRAM  = 3'h4;
  localparam logic [2:0] DEV_OTHER = 3'h2;
  // bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {RG_NONE, RG_IRAM, RG_PERIPH, RG_DRAM, RG_FLASH} region_type;
  typedef enum logic [1:0] {P_IDLE = 2'b01, P_BUSY = 2'b10} port_state_type;

  typedef struct packed {
    port_state_type fs;        // fetch port state
    port_state_type ds;        // data port state
    logic [3:0]     fc;        // fetch cycles left
    logic [3:0]     dc;        // data cycles left
    logic [23:0]    fa;        // fetch address
    logic [23:0]    da;        // data address
    logic [1:0]     dsz;       // data access size
    logic           dwe;       // data write
    logic           dstk;      // stacking access
    logic [31:0]    dwd;       // data write word
    logic           fdone;     // fetch done pulse
    logic           ddone;     // data done pulse
    logic [15:0]    frd;       // fetch read word
    logic [31:0]    drd;       // data read word
    logic           unlocked;  // protection released
    logic [1:0]     fwait;     // flash read wait select
    logic [2:0]     ramsel;    // ram size limit select
    logic           awrdy;
    logic           wrdy;
    logic           arrdy;
    logic           bvalid;
    logic           rvalid;
    logic [1:0]     bresp;
    logic [1:0]     rresp;
    logic [11:0]    awa;
    logic [11:0]    ara;
    logic [31:0]    wd;
    logic [3:0]     ws;
    logic [31:0]    rd;
    logic [23:0]    vbase;     // vector table base
  } state_type;
endpackage

/* File: dv/core_model.sv */
`timescale 1ns/1ps
`default_nettype none
// cpu side: holds each request until its done pulse
module core_model (
  input  wire logic        aclk,
  output var  logic        f_req,
  output var  logic [23:0] f_addr,
  input  wire logic [15:0] f_rdata,
  input  wire logic        f_done,
  output var  logic        d_req,
  output var  logic [23:0] d_addr,
  output var  logic [1:0]  d_size,
  output var  logic        d_we,
  output var  logic        d_stack,
  output var  logic [31:0] d_wdata,
  input  wire logic [31:0] d_rdata,
  input  wire logic        d_done
);
  // idle at time zero
  initial {f_req, f_addr, d_req, d_addr, d_size, d_we, d_stack, d_wdata} = '0;
  // n is cycles from take to done; sampled before the edge lands
  task automatic data(input logic [23:0] a, input logic [1:0] s, input logic w, input logic k,
                      input logic [31:0] v, output logic [31:0] r, output int n);
    @(posedge aclk);
    {d_req, d_addr, d_size, d_we, d_stack, d_wdata} <= {1'b1, a, s, w, k, v};
    n = -2;
    do begin
      @(posedge aclk);
      n++;
    end while (d_done !== 1'b1);
    r = d_rdata;
    d_req <= 1'b0;
  endtask
  // fetch port, halfword wide
  task automatic fetch(input logic [23:0] a, output logic [15:0] r, output int n);
    @(posedge aclk);
    {f_req, f_addr} <= {1'b1, a};
    n = -2;
    do begin
      @(posedge aclk);
      n++;
    end while (f_done !== 1'b1);
    r = f_rdata;
    f_req <= 1'b0;
  endtask
endmodule // core_model
`default_nettype wire

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000, r;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  e;
  logic [15:0] fr;
  wire logic        awready, wready, bvalid, arready, rvalid, f_req, f_done, d_req, d_we, d_stack, d_done;
  wire logic [1:0]  bresp, rresp, d_size;
  wire logic [31:0] rdata, d_rdata, d_wdata;
  wire logic [23:0] f_addr, d_addr, vector_base;
  wire logic [15:0] f_rdata;
  int          num_errors = 0, samples_checked = 0, n, nf;
  system_memory_bus u_dut (.*);
  core_model u_core (.*);
  always #25 aclk = ~aclk;
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // axi write: aw and w offered together, each dropped once taken
  task automatic axw(input logic [11:0] a, input logic [31:0] v);
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, v, 3'b111};
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    e = bresp;
    bready <= 1'b0;
  endtask
  task automatic axr(input logic [11:0] a);
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    {r, e} = {rdata, rresp};
    rready <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk(vector_base, 32'h0000_8000);
    axr(smb_pkg::OFS_DBG);
    chk(r, 32'h0000_07c0);
    axr(12'h100);
    chk(e, smb_pkg::RESP_SLVERR);
    axw(12'h100, 32'h0000_0000);
    chk(e, smb_pkg::RESP_SLVERR);
    axw(smb_pkg::OFS_FLASH, 32'h0000_0000);
    axr(smb_pkg::OFS_FLASH);
    chk(r, 32'h0000_0003);
    u_core.data(24'h00_8000, 2'h2, 1'b1, 1'b0, 32'h0012_3456, r, n);
    u_core.data(24'h00_8000, 2'h2, 1'b0, 1'b0, 32'h0, r, n);
    chk(n, 8);
    u_core.data(24'h00_8000, 2'h1, 1'b0, 1'b0, 32'h0, r, n);
    chk(n, 4);
    chk(r, 32'h0000_3456);
    axw(smb_pkg::OFS_PROTECT, 32'h0000_0096);
    chk(e, smb_pkg::RESP_OKAY);
    axw(smb_pkg::OFS_FLASH, 32'h0000_0000);
    u_core.data(24'h00_8000, 2'h2, 1'b0, 1'b0, 32'h0, r, n);
    chk(n, 2);
    $display("test regs done");
  endtask
  task automatic t_width;
    u_core.data(24'h00_0010, 2'h2, 1'b1, 1'b0, 32'hab34_5678, r, n);
    chk(n, 1);
    u_core.data(24'h00_0010, 2'h2, 1'b0, 1'b0, 32'h0, r, n);
    chk(r, 32'h0034_5678);
    u_core.data(24'h00_0020, 2'h2, 1'b1, 1'b1, 32'hab34_5678, r, n);
    u_core.data(24'h00_0020, 2'h2, 1'b0, 1'b1, 32'h0, r, n);
    chk(r, 32'hab34_5678);
    u_core.data(24'h00_6000, 2'h2, 1'b1, 1'b0, 32'h0056_789a, r, n);
    chk(n, 2);
    u_core.data(24'h00_6000, 2'h2, 1'b0, 1'b0, 32'h0, r, n);
    chk(r, 32'h0056_789a);
    for (int s = 0; s < 3; s++) begin
      u_core.data(24'h00_4008, s[1:0], 1'b0, 1'b0, 32'h0, r, n);
      chk(n, (s == 2) ? 2 : 1);
    end
    $display("test width done");
  endtask
  task automatic t_size;
    axw(smb_pkg::OFS_RAMSZ, 32'h0000_0001);
    axr(smb_pkg::OFS_DBG);
    chk(r, 32'h0000_03c0);
    u_core.data(24'h00_0500, 2'h1, 1'b1, 1'b0, 32'h0000_1234, r, n);
    u_core.data(24'h00_0500, 2'h1, 1'b0, 1'b0, 32'h0, r, n);
    chk(r, 32'h0000_0000);
    $display("test size done");
  endtask
  task automatic t_share;
    fork
      u_core.fetch(24'h00_8000, fr, nf);
      u_core.data(24'h00_0010, 2'h2, 1'b0, 1'b0, 32'h0, r, n);
    join
    chk(nf, 1);
    chk(n, 1);
    chk(r, 32'h0034_5678);
    chk(fr, 32'h0000_3456);
    fork
      u_core.fetch(24'h00_8000, fr, nf);
      u_core.data(24'h00_6000, 2'h1, 1'b0, 1'b0, 32'h0, r, n);
    join
    chk(nf, 2);
    chk(n, 1);
    chk(r, 32'h0000_789a);
    $display("test share done");
  endtask
  ////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // watchdog, far above the hundred-odd cycles the tests take
  initial begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_width();
    t_size();
    t_share();
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
